// file: pkg/ptb_pkg.sv
package ptb_pkg;
  // Bus address and command codes
  localparam logic [6:0] SLAVE_ADDR = 7'h0d;
  localparam logic [7:0] CMD_PTR = 8'hb0;
  localparam logic [7:0] CMD_BLK_WR = 8'ha0;
  localparam logic [7:0] CMD_BLK_RD = 8'ha1;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // Count after the acknowledge clock has risen
  localparam logic [3:0] END_BIT = 4'h9;

  // Transaction phases
  typedef enum logic [2:0] {
    PTB_IDLE, PTB_ADDR, PTB_CMD, PTB_PTR, PTB_CNT, PTB_WDATA, PTB_RDATA, PTB_SKIP
  } ptb_state_t;

  // Register-space access toward the device core
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } ptb_wr_t;
endpackage : ptb_pkg

// file: logic/ptb_slave.sv
`timescale 1ns/1ps
module ptb_slave
  import ptb_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Serial bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Register space
  output ptb_wr_t o_reg_wr,
  output logic [7:0] o_reg_raddr,
  input wire logic [7:0] i_reg_rdata,
  // Status
  output logic [7:0] o_pointer
);

  // Three-stage samplers; the first stage feeds only the second
  logic [2:0] scl_sy;
  logic [2:0] sda_sy;
  logic scl;
  logic sda;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_sy <= 3'h7;
      sda_sy <= 3'h7;
      scl <= 1'b1;
      sda <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[1:0], i_scl};
      sda_sy <= {sda_sy[1:0], i_sda};
      if (scl_sy[1] == scl_sy[2]) scl <= scl_sy[2];
      if (sda_sy[1] == sda_sy[2]) sda <= sda_sy[2];
    end
  end

  // Bus events from the filtered lines
  logic scl_d;
  logic sda_d;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = scl & ~scl_d;
  assign scl_fall = ~scl & scl_d;
  assign start_ev = scl & scl_d & sda_d & ~sda;
  assign stop_ev = scl & scl_d & ~sda_d & sda;

  ptb_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [7:0] ptr;
  logic [7:0] reg_addr;
  logic blk_rd;
  logic single_wr;
  logic rd_dir;
  logic drive_ack;
  logic mack;

  // Byte completes on the rising edge of its eighth data bit
  logic byte_done;
  logic [7:0] rx_byte;
  assign byte_done = scl_rise && (bitcnt == LAST_BIT) && !rd_dir && (state != PTB_IDLE);
  assign rx_byte = {shreg[6:0], sda};

  // Bit counter and receive shift on rising clock edges; the count runs on
  // through the acknowledge clock so that its low and high halves stay apart
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bitcnt <= 4'h0;
      shreg <= 8'h00;
    end else if (start_ev || stop_ev) begin
      bitcnt <= 4'h0;
    end else if (scl_fall && bitcnt == END_BIT) begin
      bitcnt <= 4'h0;
    end else if (scl_rise && bitcnt != END_BIT) begin
      shreg <= rx_byte;
      bitcnt <= bitcnt + 4'h1;
    end
  end

  // Master acknowledge sampled in the ninth bit of a read byte
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) mack <= 1'b0;
    else if (scl_rise && bitcnt == ACK_BIT && rd_dir) mack <= ~sda;
  end

  // Transaction phase machine
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= PTB_IDLE;
      rd_dir <= 1'b0;
      blk_rd <= 1'b0;
      single_wr <= 1'b0;
      reg_addr <= 8'h00;
    end else if (stop_ev) begin
      state <= PTB_IDLE;
      rd_dir <= 1'b0;
      blk_rd <= 1'b0;
    end else if (start_ev) begin
      // Block read flag survives the repeated start
      state <= PTB_ADDR;
      rd_dir <= 1'b0;
    end else if (byte_done) begin
      case (state)
        PTB_ADDR: begin
          if (rx_byte[7:1] == SLAVE_ADDR) begin
            state <= rx_byte[0] ? PTB_RDATA : PTB_CMD;
            rd_dir <= rx_byte[0];
          end else begin
            state <= PTB_SKIP;
          end
        end
        PTB_CMD: begin
          blk_rd <= 1'b0;
          single_wr <= 1'b0;
          case (rx_byte)
            CMD_PTR: state <= PTB_PTR;
            CMD_BLK_WR: state <= PTB_CNT;
            CMD_BLK_RD: begin
              state <= PTB_CNT;
              blk_rd <= 1'b1;
            end
            default: begin
              state <= PTB_WDATA;
              single_wr <= 1'b1;
              reg_addr <= rx_byte;
            end
          endcase
        end
        PTB_PTR: state <= PTB_SKIP;
        PTB_CNT: state <= blk_rd ? PTB_SKIP : PTB_WDATA;
        PTB_WDATA: state <= single_wr ? PTB_SKIP : PTB_WDATA;
        default: state <= state;
      endcase
    end else if (state == PTB_RDATA && scl_fall && bitcnt == END_BIT && !mack) begin
      state <= PTB_SKIP;
    end
  end

  // Pointer, register writes
  logic rd_byte_end;
  // Advance as the master's ack slot opens, so the next fetch already sees it
  assign rd_byte_end = state == PTB_RDATA && scl_fall && bitcnt == ACK_BIT && !drive_ack;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ptr <= PTR_RST;
      o_reg_wr <= '0;
    end else begin
      o_reg_wr.wr <= 1'b0;
      if (byte_done && state == PTB_PTR) begin
        ptr <= rx_byte;
      end else if (byte_done && state == PTB_WDATA) begin
        o_reg_wr.wr <= 1'b1;
        o_reg_wr.data <= rx_byte;
        o_reg_wr.addr <= single_wr ? reg_addr : ptr;
        if (!single_wr) ptr <= ptr + 8'h01;
      end else if (rd_byte_end && blk_rd) begin
        ptr <= ptr + 8'h01;
      end
    end
  end
  assign o_reg_raddr = ptr;
  assign o_pointer = ptr;

  // Acknowledge after each accepted write byte
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) drive_ack <= 1'b0;
    else if (start_ev || stop_ev) drive_ack <= 1'b0;
    else if (scl_fall && bitcnt == END_BIT) drive_ack <= 1'b0;
    else if (byte_done && state != PTB_SKIP &&
             !(state == PTB_ADDR && rx_byte[7:1] != SLAVE_ADDR)) drive_ack <= 1'b1;
  end

  // Read shifter; shifts on falling clock edges, loads on a falling edge or as a read address byte completes
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      txreg <= 8'hff;
    end else if (scl_fall && state == PTB_RDATA) begin
      if (bitcnt == END_BIT) txreg <= i_reg_rdata;
      else if (bitcnt != ACK_BIT) txreg <= {txreg[6:0], 1'b1};
      else txreg <= 8'hff;
    end else if (byte_done && state == PTB_ADDR && rx_byte[0]) begin
      txreg <= i_reg_rdata; // loaded while clock still high, replaced by 8'hff at the next fall
    end
  end

  // Data line drive: acknowledge or read bit, open-drain style
  logic rd_drive;
  assign rd_drive = state == PTB_RDATA && rd_dir && bitcnt != ACK_BIT && !drive_ack;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sda_oe <= 1'b0;
    end else if (scl_fall || start_ev || stop_ev) begin
      o_sda_oe <= 1'b0;
    end else if (!scl) begin
      o_sda_oe <= drive_ack || (rd_drive && !txreg[7]);
    end
  end
  assign o_sda_out = 1'b0;

  // Assertions
  a_ptr_load: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (byte_done && state == PTB_PTR) |=> ptr == $past(rx_byte))
    else $error("pointer not loaded");
  a_sda_stable: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (scl && scl_d) |-> $stable(o_sda_oe) || start_ev || stop_ev || $past(scl_fall))
    else $error("data changed while clock high");
  a_foreign_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (byte_done && state == PTB_ADDR && rx_byte[7:1] != SLAVE_ADDR) |=> !drive_ack)
    else $error("acked foreign address");
  a_wr_ack: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (byte_done && state inside {PTB_CMD, PTB_PTR, PTB_CNT, PTB_WDATA}) |=> drive_ack)
    else $error("write byte not acked");

  // Multi-step behaviours
  sequence s_nack_end;
    state == PTB_RDATA && scl_fall && bitcnt == END_BIT && !mack;
  endsequence
  sequence s_released;
    (state == PTB_SKIP && !o_sda_oe) [*2];
  endsequence
  sequence s_wr_pulse;
    o_reg_wr.wr ##1 !o_reg_wr.wr;
  endsequence
  a_nack_release: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    s_nack_end |=> s_released)
    else $error("line held after not-ack");
  a_wr_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (byte_done && state == PTB_WDATA) |=> s_wr_pulse)
    else $error("register write not a single pulse");
  a_rd_advance: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (rd_byte_end && blk_rd) |=> ptr == $past(ptr) + 8'h01)
    else $error("pointer not advanced after read byte");
endmodule : ptb_slave

// file: tb/ptb_master.sv
`timescale 1ns/1ps
module ptb_master (
  // Clock and bus
  input wire logic i_ref_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // Bus idles high, released
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // One half step: pins change just after an edge, then hold; long enough
  // for the slave's samplers to see the fall and drive before the rise
  task automatic st(input logic c, input logic d);
    o_scl <= c;
    o_sda <= d;
    repeat (8) @(posedge i_ref_clk);
  endtask : st

  // Data moves only while the clock is low; sampled at end of high
  task automatic bit_x(input logic d, output logic q);
    st(1'b0, d);
    st(1'b1, d);
    q = i_sda;
  endtask : bit_x

  task automatic start();
    st(1'b1, 1'b1);
    st(1'b1, 1'b0);
  endtask : start

  task automatic restart();
    st(1'b0, 1'b1);
    start();
  endtask : restart

  task automatic stop();
    st(1'b0, 1'b0);
    st(1'b1, 1'b0);
    st(1'b1, 1'b1);
  endtask : stop

  // Byte out, MSB first; ninth bit released to read the ack
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) bit_x(b[i], q);
    bit_x(1'b1, q);
    ack = ~q;
  endtask : wr_byte

  // Byte in; ack all but the last, which gets a not-ack
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, q);
      b[i] = q;
    end
    bit_x(last, q);
  endtask : rd_byte
endmodule : ptb_master

// file: tb/test_i2c_pointer_block_access.sv
`timescale 1ns/1ps
module test_i2c_pointer_block_access
  import ptb_pkg::*;
;
  localparam logic [7:0] WA = {SLAVE_ADDR, 1'b0};
  localparam logic [7:0] RA = {SLAVE_ADDR, 1'b1};
  logic clk, rstn, scl, m_sda, oe, sd_o, a;
  logic [7:0] raddr, ptr, d0, d1;
  ptb_wr_t wr_bus, lw;
  int num_errors = 0, n_checks = 0, nw = 0, n0;
  // Open-drain wire with pull-up: low if anyone pulls
  wire sda = m_sda & ~(oe & ~sd_o);
  // Register core returns a pattern of its address
  wire [7:0] rdata = raddr ^ 8'h5a;

  ptb_slave uut (.i_ref_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sd_o), .o_sda_oe(oe), .o_reg_wr(wr_bus), .o_reg_raddr(raddr),
    .i_reg_rdata(rdata), .o_pointer(ptr));
  ptb_master m (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));

  // Log register writes
  always @(posedge clk) if (wr_bus.wr === 1'b1) begin
    lw <= wr_bus;
    nw <= nw + 1;
  end

  task automatic close_out();
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic ok, input string s);
    n_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, s);
    end
  endtask : chk

  // Address then bytes, each expected acked
  task automatic send(input logic [7:0] q[$]);
    m.start();
    foreach (q[i]) begin
      m.wr_byte(q[i], a);
      chk(a === 1'b1, "missing ack");
    end
  endtask : send

  task automatic sc_ptr(input logic [7:0] p);
    send('{WA, CMD_PTR, p});
    m.stop();
    chk(ptr === p, "pointer value");
  endtask : sc_ptr

  task automatic sc_single();
    n0 = nw;
    send('{WA, 8'h42, 8'h99});
    m.stop();
    chk(nw - n0 == 1 && lw.addr === 8'h42 && lw.data === 8'h99, "single write");
  endtask : sc_single

  task automatic sc_recv();
    sc_ptr(8'h35);
    m.start();
    m.wr_byte(RA, a);
    m.rd_byte(1'b1, d0);
    m.stop();
    chk(a === 1'b1 && d0 === 8'h6f, "receive byte");
    chk(ptr === 8'h35, "pointer moved by receive");
  endtask : sc_recv

  task automatic sc_blkwr();
    sc_ptr(8'h10);
    n0 = nw;
    send('{WA, CMD_BLK_WR, 8'h02, 8'hc3, 8'h3c});
    m.stop();
    chk(nw - n0 == 2 && lw.addr === 8'h11 && lw.data === 8'h3c, "block write");
  endtask : sc_blkwr

  task automatic sc_blkrd();
    sc_ptr(8'h20);
    send('{WA, CMD_BLK_RD, 8'h02});
    m.restart();
    m.wr_byte(RA, a);
    m.rd_byte(1'b0, d0);
    m.rd_byte(1'b1, d1);
    chk(a === 1'b1 && d0 === 8'h7a && d1 === 8'h7b, "block read");
    chk(oe === 1'b0, "line held after not-ack");
    m.stop();
    chk(ptr === 8'h22, "pointer after block read");
  endtask : sc_blkrd

  task automatic sc_foreign();
    n0 = nw;
    m.start();
    m.wr_byte({7'h0e, 1'b0}, a);
    m.wr_byte(8'h42, d0[0]);
    m.stop();
    chk(a === 1'b0 && nw == n0, "foreign address answered");
  endtask : sc_foreign

  // Clock at 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Watchdog cuts a hang short
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    close_out();
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    sc_single();
    sc_recv();
    sc_blkwr();
    sc_blkrd();
    sc_foreign();
    close_out();
  end
endmodule : test_i2c_pointer_block_access
